// ==== design/tlim_alarm.sv ====
// Notes on behaviour
// [R1] Conversion start samples open-diode comparator, sets bit 2
// [R2] Open flag drives alarm low in alarm mode
// [R3] Alarm maskable; fail-safe output never masked
// [R4] Alarm on above high or at/below low
// [R5] Release needs alert response, clear condition, clear status
// [R6] Fail-safe low when channel above fail-safe limit
// [R7] Fail-safe self-releases at limit minus hysteresis
// [R8] Fail-safe limits reset to 85 degrees
// [R9] Hysteresis resets to 10, freely rewritable
// [R10] Hysteresis is unsigned whole degrees
// [R11] Shared pin: alarm or second fail-safe
// [R12] Second fail-safe trips above high limits, unmasked
// [R13] Second fail-safe release lowered by hysteresis
// [R14] Either channel asserts each fail-safe output
// [R15] Host answers alert, then clears status
// [R16] Host sets fail-safe limits at or above high
// [R17] Alert response returns own address, low bit one
// [R18] Standby limit writes re-check stored temperatures
// [R19] Comparisons re-run on each stored result
`timescale 1ns/1ns
`default_nettype none
module tlim_alarm #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire tlim_pkg::tlim_regreq_s regReq,
    output logic [7:0] regRdata,
    // Conversion results and conversion start
    input wire tlim_pkg::tlim_result_s locResult,
    input wire tlim_pkg::tlim_result_s remResult,
    input wire logic convStart,
    // Open-diode comparator, asynchronous
    input wire logic openFault,
    // Alert response from the protocol engine
    input wire logic araReq,
    output logic araAck,
    output logic [7:0] araByte,
    // Shared open-drain pin: alarm or second fail-safe
    input wire logic alertPinIn,
    output logic alertPinOut,
    output logic alertPinOe,
    // Fail-safe open-drain pin
    input wire logic failsafeOvertempIn,
    output logic failsafeOvertempOutN,
    output logic failsafeOvertempOe,
    // Interrupt
    output logic irq
);

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [7:0] cfg;
        logic [tlim_pkg::ST_W-1:0] status;
        logic [tlim_pkg::ST_W-1:0] mask;
        logic [7:0] hyst;
        logic [tlim_pkg::NUM_LIMITS-1:0][7:0] limits;
        logic [1:0][7:0] temps;
        logic [tlim_pkg::ST_W-1:0] condNow;
        logic [3:0] trip;
        logic pendEval;
        logic alertActive;
        logic araServed;
        logic irq;
        logic alertOe;
        logic fsOe;
        logic pinLow;
        logic araAck;
        logic [7:0] araByte;
        logic [7:0] rdata;
    } tlim_state_s;

    tlim_state_s cur_r;
    tlim_state_s cur_nxt;
    logic [2:0] pinsSync;
    logic [1:0][7:0] effTemp;
    logic [3:0] tripNxt;
    logic [3:0][7:0] tripLimit;
    logic [3:0][7:0] tripTemp;

    // ********************************
    // Helpers
    // ********************************
    // High and low comparisons for both channels
    function automatic logic [tlim_pkg::ST_W-1:0] limit_flags(
        input logic [1:0][7:0] t,
        input logic [tlim_pkg::NUM_LIMITS-1:0][7:0] lim
    );
        logic [tlim_pkg::ST_W-1:0] f;
        f = '0;
        f[tlim_pkg::ST_LOC_HIGH] = t[0] > lim[tlim_pkg::LIM_LOC_HIGH]; // [R4]
        f[tlim_pkg::ST_LOC_LOW] = t[0] <= lim[tlim_pkg::LIM_LOC_LOW]; // [R4]
        f[tlim_pkg::ST_REM_HIGH] = t[1] > lim[tlim_pkg::LIM_REM_HIGH]; // [R4]
        f[tlim_pkg::ST_REM_LOW] = t[1] <= lim[tlim_pkg::LIM_REM_LOW]; // [R4]
        return f;
    endfunction

    // Limit slot decode, used for write and read
    function automatic logic is_limit(input logic [7:0] a);
        return (a >= tlim_pkg::OFF_LIMIT_FIRST) && (a <= tlim_pkg::OFF_LIMIT_LAST);
    endfunction

    function automatic logic [2:0] limit_slot(input logic [7:0] a);
        logic [7:0] d;
        d = a - tlim_pkg::OFF_LIMIT_FIRST;
        return d[2:0];
    endfunction

    // ********************************
    // Pin and comparator synchronisers
    // ********************************
    tlim_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn({openFault, failsafeOvertempIn, alertPinIn}),
        .syncOut(pinsSync)
    );

    // ********************************
    // Fail-safe comparators with hysteresis
    // ********************************
    // A result arriving this cycle is compared at once
    assign effTemp[0] = locResult.valid ? locResult.temp : cur_r.temps[0]; // [R19]
    assign effTemp[1] = remResult.valid ? remResult.temp : cur_r.temps[1]; // [R19]

    // Slots 0,1 use fail-safe limits; 2,3 use high limits
    assign tripLimit[0] = cur_r.limits[tlim_pkg::LIM_LOC_FS]; // [R6]
    assign tripLimit[1] = cur_r.limits[tlim_pkg::LIM_REM_FS]; // [R6]
    assign tripLimit[2] = cur_r.limits[tlim_pkg::LIM_LOC_HIGH]; // [R12]
    assign tripLimit[3] = cur_r.limits[tlim_pkg::LIM_REM_HIGH]; // [R12]
    assign tripTemp[0] = effTemp[0];
    assign tripTemp[1] = effTemp[1];
    assign tripTemp[2] = effTemp[0];
    assign tripTemp[3] = effTemp[1];

    generate
        for (genvar i = 0; i < 4; i++) begin : g_trip
            tlim_fs_hyst_cmp u_cmp (
                .tripped(cur_r.trip[i]),
                .temp(tripTemp[i]),
                .limit(tripLimit[i]),
                .hyst(cur_r.hyst), // [R13]
                .tripNxt(tripNxt[i])
            );
        end
    endgenerate

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        logic [tlim_pkg::ST_W-1:0] flags;
        logic [tlim_pkg::ST_W-1:0] unmasked;
        logic evalNow;
        logic alertMode;
        cur_nxt = cur_r;
        flags = '0;
        unmasked = '0;
        evalNow = 1'b0;
        alertMode = cur_r.cfg[tlim_pkg::CFG_PIN_MODE] == tlim_pkg::TLIM_PIN_ALERT; // [R11]
        cur_nxt.araAck = 1'b0;
        cur_nxt.rdata = 8'h00;
        cur_nxt.pinLow = 1'b0;
        cur_nxt.pendEval = 1'b0;

        // Register writes; status bits clear on writing one
        if (regReq.wr) begin
            if (regReq.addr == tlim_pkg::OFF_CONFIG) begin
                cur_nxt.cfg = regReq.wdata;
            end else if (regReq.addr == tlim_pkg::OFF_STATUS) begin
                cur_nxt.status = cur_r.status & ~regReq.wdata[tlim_pkg::ST_W-1:0];
            end else if (regReq.addr == tlim_pkg::OFF_MASK) begin
                cur_nxt.mask = regReq.wdata[tlim_pkg::ST_W-1:0];
            end else if (regReq.addr == tlim_pkg::OFF_HYST) begin
                cur_nxt.hyst = regReq.wdata; // Any value taken [R9] [R10]
            end else if (is_limit(regReq.addr)) begin
                cur_nxt.limits[limit_slot(regReq.addr)] = regReq.wdata;
                cur_nxt.pendEval = cur_r.cfg[tlim_pkg::CFG_STANDBY]; // [R18]
            end
        end

        // Register reads; data stands one cycle
        if (regReq.rd) begin
            if (regReq.addr == tlim_pkg::OFF_CONFIG) begin
                cur_nxt.rdata = cur_r.cfg;
            end else if (regReq.addr == tlim_pkg::OFF_STATUS) begin
                cur_nxt.rdata = {3'h0, cur_r.status};
            end else if (regReq.addr == tlim_pkg::OFF_MASK) begin
                cur_nxt.rdata = {3'h0, cur_r.mask};
            end else if (regReq.addr == tlim_pkg::OFF_HYST) begin
                cur_nxt.rdata = cur_r.hyst;
            end else if (is_limit(regReq.addr)) begin
                cur_nxt.rdata = cur_r.limits[limit_slot(regReq.addr)];
            end else if (regReq.addr == tlim_pkg::OFF_LOC_TEMP) begin
                cur_nxt.rdata = cur_r.temps[0];
            end else if (regReq.addr == tlim_pkg::OFF_REM_TEMP) begin
                cur_nxt.rdata = cur_r.temps[1];
            end else if (regReq.addr == tlim_pkg::OFF_PINS) begin
                cur_nxt.rdata = {5'h00, pinsSync};
            end
        end

        // Store results; a standby limit write re-checks next cycle
        cur_nxt.temps = effTemp;
        evalNow = locResult.valid | remResult.valid | cur_r.pendEval; // [R18] [R19]
        if (evalNow) begin
            flags = limit_flags(effTemp, cur_r.limits);
            cur_nxt.condNow[tlim_pkg::ST_W-1:0] = flags | (cur_r.condNow & 5'h04);
            cur_nxt.status = cur_nxt.status | flags; // Set wins over clear [R4]
        end

        // Open-diode check at conversion start, skipped in standby
        if (convStart && !cur_r.cfg[tlim_pkg::CFG_STANDBY]) begin
            cur_nxt.condNow[tlim_pkg::ST_OPEN] = pinsSync[2];
            if (pinsSync[2]) begin
                cur_nxt.status[tlim_pkg::ST_OPEN] = 1'b1; // [R1]
            end
        end

        // Alert response served only while asserted
        if (araReq && cur_r.alertActive) begin
            cur_nxt.araAck = 1'b1;
            cur_nxt.araByte = {DEV_ADDR, 1'b1}; // [R17]
            cur_nxt.araServed = 1'b1;
        end

        // Alarm latch; release needs all three conditions
        unmasked = cur_nxt.status & ~cur_nxt.mask; // [R3]
        if (alertMode && |unmasked) begin
            cur_nxt.alertActive = 1'b1; // [R2] [R4]
        end else if (cur_r.alertActive && cur_r.araServed && cur_r.status == '0
                     && cur_r.condNow == '0) begin
            cur_nxt.alertActive = 1'b0; // [R5]
            cur_nxt.araServed = 1'b0;
        end
        cur_nxt.irq = |unmasked;

        // Fail-safe states and pin drive
        cur_nxt.trip = tripNxt;
        cur_nxt.fsOe = tripNxt[0] | tripNxt[1]; // Unmasked [R3] [R6] [R14]
        if (alertMode) begin
            cur_nxt.alertOe = cur_nxt.alertActive;
        end else begin
            cur_nxt.alertOe = tripNxt[2] | tripNxt[3]; // [R11] [R12] [R14]
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_r <= '0;
            cur_r.cfg <= tlim_pkg::CONFIG_RST;
            cur_r.mask <= tlim_pkg::MASK_RST;
            cur_r.hyst <= tlim_pkg::HYST_DEGC; // [R9]
            cur_r.limits[tlim_pkg::LIM_LOC_HIGH] <= tlim_pkg::HIGH_LIMIT_RST;
            cur_r.limits[tlim_pkg::LIM_LOC_LOW] <= tlim_pkg::LOW_LIMIT_RST;
            cur_r.limits[tlim_pkg::LIM_REM_HIGH] <= tlim_pkg::HIGH_LIMIT_RST;
            cur_r.limits[tlim_pkg::LIM_REM_LOW] <= tlim_pkg::LOW_LIMIT_RST;
            cur_r.limits[tlim_pkg::LIM_LOC_FS] <= tlim_pkg::FAILSAFE_LIMIT_DEGC; // [R8]
            cur_r.limits[tlim_pkg::LIM_REM_FS] <= tlim_pkg::FAILSAFE_LIMIT_DEGC; // [R8]
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ********************************
    // Outputs, all from flops
    // ********************************
    // Open-drain pins only ever pull low; the enable carries the level
    assign regRdata = cur_r.rdata;
    assign araAck = cur_r.araAck;
    assign araByte = cur_r.araByte;
    assign alertPinOut = cur_r.pinLow;
    assign alertPinOe = cur_r.alertOe;
    assign failsafeOvertempOutN = cur_r.pinLow;
    assign failsafeOvertempOe = cur_r.fsOe;
    assign irq = cur_r.irq;

endmodule
`default_nettype wire

// ==== design/tlim_fs_hyst_cmp.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlim_fs_hyst_cmp (
    // Present trip state
    input wire logic tripped,
    // Temperature and thresholds
    input wire logic [7:0] temp,
    input wire logic [7:0] limit,
    input wire logic [7:0] hyst,
    // Next trip state
    output logic tripNxt
);

    logic [7:0] releasePoint;

    // Release point floors at zero so a large hysteresis never wraps
    always_comb begin
        releasePoint = (hyst > limit) ? 8'h00 : 8'(limit - hyst);
        if (temp > limit) begin
            tripNxt = 1'b1;
        end else if (temp <= releasePoint) begin
            tripNxt = 1'b0; // Self release, no host action [R7] [R13]
        end else begin
            tripNxt = tripped;
        end
    end

endmodule
`default_nettype wire

// ==== design/tlim_pkg.sv ====
package tlim_pkg;

    // ********************************
    // Widths and register offsets
    // ********************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h01;
    localparam logic [7:0] OFF_MASK = 8'h02;
    localparam logic [7:0] OFF_HYST = 8'h03;
    localparam logic [7:0] OFF_LIMIT_FIRST = 8'h04;
    localparam logic [7:0] OFF_LIMIT_LAST = 8'h09;
    localparam logic [7:0] OFF_LOC_TEMP = 8'h0A;
    localparam logic [7:0] OFF_REM_TEMP = 8'h0B;
    localparam logic [7:0] OFF_PINS = 8'h0C;

    // ********************************
    // Limit table slots (offset minus first limit offset)
    // ********************************
    localparam int LIM_LOC_HIGH = 0;
    localparam int LIM_LOC_LOW = 1;
    localparam int LIM_REM_HIGH = 2;
    localparam int LIM_REM_LOW = 3;
    localparam int LIM_LOC_FS = 4;
    localparam int LIM_REM_FS = 5;
    localparam int NUM_LIMITS = 6;

    // ********************************
    // Field positions
    // ********************************
    localparam int CFG_PIN_MODE = 0;
    localparam int CFG_STANDBY = 1;
    localparam int ST_LOC_HIGH = 0;
    localparam int ST_LOC_LOW = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_REM_HIGH = 3;
    localparam int ST_REM_LOW = 4;
    localparam int ST_W = 5;

    // ********************************
    // Values after reset; limits and hysteresis in degrees (one degree per bit)
    // ********************************
    localparam logic [7:0] FAILSAFE_LIMIT_DEGC = 8'h55;
    localparam logic [7:0] HYST_DEGC = 8'h0A;
    localparam logic [7:0] HIGH_LIMIT_RST = 8'h55;
    localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [4:0] MASK_RST = 5'h00;

    // ********************************
    // Types
    // ********************************
    typedef enum logic {
        TLIM_PIN_ALERT = 1'b0,
        TLIM_PIN_FAILSAFE2 = 1'b1
    } tlim_pinmode_e;

    typedef struct packed {
        logic valid;
        logic [7:0] temp;
    } tlim_result_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tlim_regreq_s;

endpackage

// ==== design/tlim_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlim_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } tlim_sync_s;

    tlim_sync_s cur_r;
    tlim_sync_s cur_nxt;

    // First stage feeds only the second stage
    always_comb begin
        cur_nxt.stage1 = asyncIn;
        cur_nxt.stage2 = cur_r.stage1;
    end

    // Two flip-flops per bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign syncOut = cur_r.stage2;

endmodule
`default_nettype wire

// ==== tb/tlim_alarm_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlim_alarm_sva #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port and results
    input wire tlim_pkg::tlim_regreq_s regReq,
    input wire logic [7:0] regRdata,
    input wire tlim_pkg::tlim_result_s locResult,
    input wire tlim_pkg::tlim_result_s remResult,
    input wire logic convStart,
    input wire logic openFault,
    // Alert response
    input wire logic araReq,
    input wire logic araAck,
    input wire logic [7:0] araByte,
    // Pins and interrupt
    input wire logic alertPinOut,
    input wire logic alertPinOe,
    input wire logic failsafeOvertempOutN,
    input wire logic failsafeOvertempOe,
    input wire logic irq
);
    // **********
    // Shadow state
    // **********
    localparam logic [7:0] FS = tlim_pkg::FAILSAFE_LIMIT_DEGC;
    localparam logic [7:0] HI = tlim_pkg::HIGH_LIMIT_RST;
    logic modeR, stbyR, limWrR, servedR;
    logic [4:0] mskR;
    logic [7:0] locT, remT, hystR;

    // Limits are only known until software rewrites them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {modeR, stbyR, limWrR, servedR} <= 4'h0;
            mskR <= tlim_pkg::MASK_RST;
            {locT, remT} <= 16'h0000;
            hystR <= tlim_pkg::HYST_DEGC;
        end else begin
            if (regReq.wr && regReq.addr == tlim_pkg::OFF_CONFIG) begin
                modeR <= regReq.wdata[tlim_pkg::CFG_PIN_MODE];
                stbyR <= regReq.wdata[tlim_pkg::CFG_STANDBY];
            end
            if (regReq.wr && regReq.addr == tlim_pkg::OFF_MASK) mskR <= regReq.wdata[4:0];
            if (regReq.wr && regReq.addr == tlim_pkg::OFF_HYST) hystR <= regReq.wdata;
            if (regReq.wr && regReq.addr >= tlim_pkg::OFF_LIMIT_FIRST && regReq.addr <= tlim_pkg::OFF_LIMIT_LAST) limWrR <= 1'b1;
            if (locResult.valid) locT <= locResult.temp;
            if (remResult.valid) remT <= remResult.temp;
            servedR <= alertPinOe && (servedR || araAck);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_open_conv;
        openFault[*4] ##0 (convStart && !modeR && !stbyR && !mskR[tlim_pkg::ST_OPEN]);
    endsequence
    sequence s_out_of_range;
        (locResult.valid && (locResult.temp > HI || locResult.temp <= tlim_pkg::LOW_LIMIT_RST)) ||
        (remResult.valid && (remResult.temp > HI || remResult.temp <= tlim_pkg::LOW_LIMIT_RST));
    endsequence

    a_ara_answer: assert property (araReq && alertPinOe && !modeR |=> araAck && araByte == {DEV_ADDR, 1'b1})
        else $error("alert response missing or wrong");
    a_ara_silent: assert property (araReq && !alertPinOe && !modeR && mskR == 5'h00 |=> !araAck)
        else $error("alert response without alarm");
    a_rdata_idle: assert property (!regReq.rd |=> regRdata == 8'h00)
        else $error("read data outside its cycle");
    a_alarm_hold: assert property (!modeR && alertPinOe && !servedR && !araAck && !regReq.wr |=> alertPinOe)
        else $error("alarm released without service");
    a_alarm_limit: assert property (!modeR && !limWrR && mskR == 5'h00 ##0 s_out_of_range |=> alertPinOe && irq)
        else $error("alarm not raised for limit");
    a_open_alarm: assert property (s_open_conv |-> ##[1:2] (alertPinOe && irq))
        else $error("open diode did not raise alarm");
    a_fs_trip: assert property (!limWrR && (locT > FS || remT > FS) |-> failsafeOvertempOe)
        else $error("fail-safe not asserted");
    a_fs_release: assert property (!limWrR && locT <= FS - hystR && remT <= FS - hystR |-> !failsafeOvertempOe)
        else $error("fail-safe not released");
    a_fs2_trip: assert property (modeR && $stable(modeR) && !limWrR && (locT > HI || remT > HI) |-> alertPinOe)
        else $error("second fail-safe not asserted");
    a_fs2_release: assert property (modeR && $stable(modeR) && !limWrR && locT <= HI - hystR && remT <= HI - hystR
        |-> !alertPinOe)
        else $error("second fail-safe not released");
    a_pins_drain: assert property (alertPinOut == 1'b0 && failsafeOvertempOutN == 1'b0)
        else $error("open-drain pin driven high");
endmodule
bind tlim_alarm tlim_alarm_sva #(.DEV_ADDR(DEV_ADDR)) tlim_alarm_sva_inst (.clk, .rst, .regReq, .regRdata,
    .locResult, .remResult, .convStart, .openFault, .araReq, .araAck, .araByte, .alertPinOut, .alertPinOe,
    .failsafeOvertempOutN, .failsafeOvertempOe, .irq);
`default_nettype wire

// ==== tb/tlim_alarm_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlim_alarm_tb;
    // **********
    // Bench signals
    // **********
    localparam logic [6:0] ADDR = 7'h2A; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    tlim_pkg::tlim_regreq_s regReq = '0;
    tlim_pkg::tlim_result_s locResult = '0;
    tlim_pkg::tlim_result_s remResult = '0;
    logic convStart = 1'b0;
    logic openFault = 1'b0;
    logic hostEn = 1'b0;
    logic [3:0] hostDelay = 4'h2;
    logic araReq, araAck, alertPinOut, alertPinOe, fsOut, fsOe, irq;
    logic [7:0] regRdata, araByte, gotByte, nAck;
    wire logic alertWire;
    wire logic fsWire;
    int nFail = 0;
    int samplesChecked = 0;
    int cycles = 0;

    // Clock, pull-ups on both open-drain wires
    always #25 clk = ~clk;
    assign alertWire = alertPinOe ? alertPinOut : 1'b1;
    assign fsWire = fsOe ? fsOut : 1'b1;

    tlim_alarm #(.DEV_ADDR(ADDR)) tlim_alarm_inst (.clk, .rst, .regReq, .regRdata, .locResult, .remResult,
        .convStart, .openFault, .araReq, .araAck, .araByte, .alertPinIn(alertWire), .alertPinOut, .alertPinOe,
        .failsafeOvertempIn(fsWire), .failsafeOvertempOutN(fsOut), .failsafeOvertempOe(fsOe), .irq);
    tlim_host_model tlim_host_model_inst (.clk, .rst, .en(hostEn), .delay(hostDelay), .alertWire, .araAck,
        .araByte, .araReq, .gotByte, .nAck);

    // **********
    // Access tasks
    // **********
    task automatic stopTest;
        $display("checks %0d, mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic flag(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        regReq <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
        chk(regRdata, exp);
    endtask
    task automatic res(input logic rem, input logic [7:0] t);
        @(posedge clk);
        if (rem) remResult <= '{valid: 1'b1, temp: t};
        else locResult <= '{valid: 1'b1, temp: t};
        @(posedge clk);
        remResult <= '0;
        locResult <= '0;
        @(negedge clk);
    endtask
    task automatic doReset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Watchdog well above the length of the sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nFail++;
            stopTest();
        end
    end

    // **********
    // Main sequence
    // **********
    initial begin
        doReset();
        rd(tlim_pkg::OFF_HYST, tlim_pkg::HYST_DEGC);
        rd(8'h08, tlim_pkg::FAILSAFE_LIMIT_DEGC);
        rd(8'h09, tlim_pkg::FAILSAFE_LIMIT_DEGC);
        rd(8'h20, 8'h00);
        // One degree over the limit, then release only at limit minus hysteresis
        res(1'b0, 8'h56);
        flag(fsOe, 1'b1);
        flag(alertPinOe, 1'b1);
        flag(irq, 1'b1);
        @(posedge clk); // Pin levels reach the register two edges late
        rd(tlim_pkg::OFF_PINS, 8'h00);
        res(1'b0, 8'h4C);
        flag(fsOe, 1'b1);
        res(1'b0, 8'h4B);
        flag(fsOe, 1'b0);
        res(1'b1, 8'h00);
        rd(tlim_pkg::OFF_STATUS, 8'h11);
        res(1'b1, 8'h30);
        wr(tlim_pkg::OFF_STATUS, 8'h1F);
        repeat (3) @(negedge clk);
        flag(irq, 1'b0);
        flag(alertPinOe, 1'b1);
        // Slow host reads the alert response
        @(posedge clk);
        hostEn <= 1'b1;
        for (int i = 0; i < 40 && alertPinOe; i++) @(negedge clk);
        flag(alertPinOe, 1'b0);
        chk(gotByte, {ADDR, 1'b1});
        chk(nAck, 8'h01);
        hostEn <= 1'b0;
        // Masked alarm beside an unmaskable fail-safe; idle remote reads as low
        doReset();
        wr(tlim_pkg::OFF_MASK, 8'h11);
        res(1'b0, 8'h60);
        flag(alertPinOe, 1'b0);
        flag(irq, 1'b0);
        flag(fsOe, 1'b1);
        // Open diode sampled at conversion start
        @(posedge clk);
        openFault <= 1'b1;
        repeat (4) @(posedge clk);
        convStart <= 1'b1;
        @(posedge clk);
        convStart <= 1'b0;
        repeat (2) @(negedge clk);
        flag(alertPinOe, 1'b1);
        rd(tlim_pkg::OFF_STATUS, 8'h15);
        @(posedge clk);
        openFault <= 1'b0;
        // Shared pin as second fail-safe on the remote channel
        doReset();
        wr(tlim_pkg::OFF_CONFIG, 8'h01);
        wr(tlim_pkg::OFF_MASK, 8'h1F);
        res(1'b1, 8'h60);
        flag(alertPinOe, 1'b1);
        flag(fsOe, 1'b1);
        wr(tlim_pkg::OFF_HYST, 8'h05);
        rd(tlim_pkg::OFF_HYST, 8'h05);
        res(1'b1, 8'h51);
        flag(alertPinOe, 1'b1);
        res(1'b1, 8'h50);
        flag(alertPinOe, 1'b0);
        flag(fsOe, 1'b0);
        // Standby: lower high limit re-checks the stored value
        doReset();
        wr(tlim_pkg::OFF_MASK, 8'h12); // Low flags from reset temperatures masked
        res(1'b0, 8'h40);
        wr(tlim_pkg::OFF_CONFIG, 8'h02);
        flag(alertPinOe, 1'b0);
        wr(8'h04, 8'h30);
        repeat (3) @(negedge clk);
        flag(alertPinOe, 1'b1);
        rd(tlim_pkg::OFF_STATUS, 8'h11);
        stopTest();
    end
endmodule
`default_nettype wire

// ==== tb/tlim_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tlim_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Service control from the bench
    input wire logic en,
    input wire logic [3:0] delay,
    // Alarm wire and alert response
    input wire logic alertWire,
    input wire logic araAck,
    input wire logic [7:0] araByte,
    output logic araReq,
    output logic [7:0] gotByte,
    output logic [7:0] nAck
);
    // **********
    // Alert servicing host
    // **********
    logic [3:0] cnt;

    // Polls the wire; a slow host leaves it low for delay cycles first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            araReq <= 1'b0;
            cnt <= 4'h0;
            gotByte <= 8'h00;
            nAck <= 8'h00;
        end else begin
            araReq <= 1'b0;
            if (araAck) begin
                gotByte <= araByte;
                nAck <= nAck + 8'h01;
            end
            if (en && !alertWire && !araReq) begin
                if (cnt == delay) begin
                    araReq <= 1'b1;
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire
